// file: aux_adc_pkg.sv
// Shared constants for the auxiliary converter control and result block
package aux_adc_pkg;
  localparam int WORD_W = 16;
  localparam int RES_W = 12;
  localparam int NUM_SLOTS = 5;

  // Command word fields
  localparam int CMD_RW_BIT = 15;
  localparam int CMD_PAGE_MSB = 14;
  localparam int CMD_PAGE_LSB = 11;
  localparam int CMD_ADDR_MSB = 10;
  localparam int CMD_ADDR_LSB = 5;
  localparam logic [3:0] WORD_LAST_BIT = 4'hF;

  // Pages and addresses
  localparam logic [3:0] PAGE_DATA = 4'h0;
  localparam logic [3:0] PAGE_CTRL = 4'h1;
  localparam logic [5:0] ADDR_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h01;
  localparam logic [5:0] ADDR_BATTERY_ONE_INPUT = 6'h05;
  localparam logic [5:0] ADDR_BATTERY_TWO_INPUT = 6'h06;
  localparam logic [5:0] ADDR_AUX = 6'h07;
  localparam logic [5:0] ADDR_TEMPERATURE_ONE = 6'h09;
  localparam logic [5:0] ADDR_TEMPERATURE_TWO = 6'h0A;
  localparam logic [5:0] ADDR_PAGE_LAST = 6'h1F;

  // Converter control fields
  localparam int CTL_BUSY_BIT = 14;
  localparam int CTL_SCAN_MSB = 13;
  localparam int CTL_SCAN_LSB = 10;
  localparam int CTL_RES_MSB = 9;
  localparam int CTL_RES_LSB = 8;

  // Status fields
  localparam int STS_PWRDN_BIT = 13;
  localparam int STS_READY_BIT = 11;

  // Scan codes
  localparam logic [3:0] SCAN_NONE = 4'h0;
  localparam logic [3:0] SCAN_BATTERY_ONE_INPUT = 4'h6;
  localparam logic [3:0] SCAN_BATTERY_TWO_INPUT = 4'h7;
  localparam logic [3:0] SCAN_AUX = 4'h8;
  localparam logic [3:0] SCAN_AUX_FN = 4'h9;
  localparam logic [3:0] SCAN_TEMPERATURE_ONE = 4'hA;
  localparam logic [3:0] SCAN_PORT = 4'hB;
  localparam logic [3:0] SCAN_TEMPERATURE_TWO = 4'hC;

  // Resolution codes
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_8 = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;

  // Result slots, in converter select order
  localparam logic [2:0] SLOT_BATTERY_ONE_INPUT = 3'h0;
  localparam logic [2:0] SLOT_BATTERY_TWO_INPUT = 3'h1;
  localparam logic [2:0] SLOT_AUX = 3'h2;
  localparam logic [2:0] SLOT_TEMPERATURE_ONE = 3'h3;
  localparam logic [2:0] SLOT_TEMPERATURE_TWO = 3'h4;

  // Reset and fill values
  localparam logic [3:0] SCAN_RESET = 4'h0;
  localparam logic [1:0] RES_RESET = 2'h0;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [15:0] READ_PAST_END = 16'hFFFF;
  localparam logic [2:0] PIN_SYNC_RESET = 3'h2;
endpackage : aux_adc_pkg

// file: pin_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : pin_sync

// file: conv_engine.sv
// Conversion sequencer: walks the inputs of a scan and stores results
`timescale 1ns/1ps
module conv_engine (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [3:0] scan_code,
  input wire logic [1:0] resolution,
  input wire logic stop,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output logic adc_start,
  output logic [2:0] adc_sel,
  output logic [1:0] adc_res,
  output logic busy,
  output logic store_valid,
  output logic [2:0] store_slot,
  output logic [11:0] store_data,
  output logic seq_done
);
  typedef enum logic [1:0] {ENG_IDLE, ENG_LAUNCH, ENG_WAIT} eng_state_t;

  eng_state_t state_ff;
  logic [2:0] slot_ff;
  logic [1:0] left_ff;
  logic [1:0] res_ff;
  logic start_ff;
  logic busy_ff;
  logic store_valid_ff;
  logic [2:0] store_slot_ff;
  logic [11:0] store_data_ff;
  logic done_ff;
  logic plan_ok;
  logic [2:0] plan_first;
  logic [1:0] plan_left;
  logic [11:0] justified;

  // Map a scan code to its first slot and remaining count
  always_comb
  begin
    plan_ok = 1'b1;
    plan_first = aux_adc_pkg::SLOT_BATTERY_ONE_INPUT;
    plan_left = 2'h0;
    case (scan_code)
      aux_adc_pkg::SCAN_BATTERY_ONE_INPUT: plan_first = aux_adc_pkg::SLOT_BATTERY_ONE_INPUT;
      aux_adc_pkg::SCAN_BATTERY_TWO_INPUT: plan_first = aux_adc_pkg::SLOT_BATTERY_TWO_INPUT;
      aux_adc_pkg::SCAN_AUX: plan_first = aux_adc_pkg::SLOT_AUX;
      aux_adc_pkg::SCAN_AUX_FN: plan_first = aux_adc_pkg::SLOT_AUX;
      aux_adc_pkg::SCAN_TEMPERATURE_ONE: plan_first = aux_adc_pkg::SLOT_TEMPERATURE_ONE;
      aux_adc_pkg::SCAN_TEMPERATURE_TWO: plan_first = aux_adc_pkg::SLOT_TEMPERATURE_TWO;
      aux_adc_pkg::SCAN_PORT: plan_left = 2'h2;
      default: plan_ok = 1'b0;
    endcase
  end

  // Clear bits above the selected resolution
  always_comb
  begin
    case (res_ff)
      aux_adc_pkg::RES_8: justified = {4'h0, adc_data[7:0]};
      aux_adc_pkg::RES_10: justified = {2'h0, adc_data[9:0]};
      default: justified = adc_data;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= ENG_IDLE;
      slot_ff <= aux_adc_pkg::SLOT_BATTERY_ONE_INPUT;
      left_ff <= 2'h0;
      res_ff <= aux_adc_pkg::RES_RESET;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (stop)
      begin
        state_ff <= ENG_IDLE;
        busy_ff <= 1'b0;
      end
      else
      begin
        case (state_ff)
          ENG_IDLE:
          begin
            if (start && plan_ok)
            begin
              slot_ff <= plan_first;
              left_ff <= plan_left;
              res_ff <= resolution;
              busy_ff <= 1'b1;
              state_ff <= ENG_LAUNCH;
            end
          end
          ENG_LAUNCH:
            state_ff <= ENG_WAIT;
          ENG_WAIT:
          begin
            if (adc_done)
            begin
              if (left_ff == 2'h0)
              begin
                state_ff <= ENG_IDLE;
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
              end
              else
              begin
                slot_ff <= slot_ff + 3'h1;
                left_ff <= left_ff - 2'h1;
                state_ff <= ENG_LAUNCH;
              end
            end
          end
          default:
            state_ff <= ENG_IDLE;
        endcase
      end
    end
  end

  // Converter start pulse and result hand-off
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_ff <= 1'b0;
      store_valid_ff <= 1'b0;
      store_slot_ff <= aux_adc_pkg::SLOT_BATTERY_ONE_INPUT;
      store_data_ff <= aux_adc_pkg::RESULT_RESET;
    end
    else
    begin
      start_ff <= (state_ff == ENG_LAUNCH) && !stop;
      store_valid_ff <= (state_ff == ENG_WAIT) && adc_done && !stop;
      if ((state_ff == ENG_WAIT) && adc_done)
      begin
        store_slot_ff <= slot_ff;
        store_data_ff <= justified;
      end
    end
  end

  assign adc_start = start_ff;
  assign adc_sel = slot_ff;
  assign adc_res = res_ff;
  assign busy = busy_ff;
  assign store_valid = store_valid_ff;
  assign store_slot = store_slot_ff;
  assign store_data = store_data_ff;
  assign seq_done = done_ff;
endmodule : conv_engine

// file: aux_adc_control_results.sv
// Serial register port, converter control and result registers
`timescale 1ns/1ps
module aux_adc_control_results (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic spi_sclk,
  input wire logic spi_ss_b,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output logic adc_start,
  output logic [2:0] adc_sel,
  output logic [1:0] adc_res,
  output logic adc_power_down,
  output logic results_ready_flag
);
  logic sclk_s;
  logic ss_b_s;
  logic mosi_s;
  logic sclk_d_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic ss_active;

  logic [3:0] bit_cnt_ff;
  logic in_cmd_ff;
  logic [15:0] shift_in_ff;
  logic [15:0] word_in;
  logic word_done;
  logic read_mode_ff;
  logic [3:0] page_ff;
  logic [5:0] ptr_ff;
  logic past_end_ff;
  logic load_pending_ff;
  logic load_fire;
  logic [15:0] shift_out_ff;
  logic miso_oe_ff;
  logic [15:0] read_word;

  logic stop_ff;
  logic [3:0] scan_ff;
  logic [1:0] res_ff;
  logic start_pulse_ff;
  logic ctl_write;
  logic host_write;
  logic stop_now;

  logic [11:0] result_ff [aux_adc_pkg::NUM_SLOTS];
  logic [aux_adc_pkg::NUM_SLOTS-1:0] unread_ff;
  logic [aux_adc_pkg::NUM_SLOTS-1:0] nxt_unread;
  logic ready_ff;

  logic eng_busy;
  logic store_valid;
  logic [2:0] store_slot;
  logic [11:0] store_data;
  logic seq_done;

  logic rd_slot_hit;
  logic [2:0] rd_slot;

  pin_sync #(
    .WIDTH(3),
    .RST_VAL(aux_adc_pkg::PIN_SYNC_RESET)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({spi_sclk, spi_ss_b, spi_mosi}),
    .sync_out({sclk_s, ss_b_s, mosi_s})
  );

  conv_engine u_conv_engine (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(start_pulse_ff),
    .scan_code(scan_ff),
    .resolution(res_ff),
    .stop(stop_now),
    .adc_done(adc_done),
    .adc_data(adc_data),
    .adc_start(adc_start),
    .adc_sel(adc_sel),
    .adc_res(adc_res),
    .busy(eng_busy),
    .store_valid(store_valid),
    .store_slot(store_slot),
    .store_data(store_data),
    .seq_done(seq_done)
  );

  // Serial clock edges seen through the synchroniser
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sclk_d_ff <= 1'b0;
    else
      sclk_d_ff <= sclk_s;
  end

  assign sclk_rise = sclk_s && !sclk_d_ff;
  assign sclk_fall = !sclk_s && sclk_d_ff;
  assign ss_active = !ss_b_s;
  assign word_in = {shift_in_ff[14:0], mosi_s};
  assign word_done = ss_active && sclk_rise
    && (bit_cnt_ff == aux_adc_pkg::WORD_LAST_BIT);
  assign load_fire = ss_active && sclk_fall && load_pending_ff;
  assign host_write = word_done && !in_cmd_ff && !read_mode_ff && !past_end_ff;
  assign ctl_write = host_write && (page_ff == aux_adc_pkg::PAGE_CTRL)
    && (ptr_ff == aux_adc_pkg::ADDR_CONTROL);
  // Stop reaches the engine as the control word lands, so no late start
  assign stop_now = stop_ff
    || (ctl_write && word_in[aux_adc_pkg::CTL_BUSY_BIT]);

  // Word framing: command word first, then data words
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_cnt_ff <= 4'h0;
      in_cmd_ff <= 1'b1;
      shift_in_ff <= 16'h0000;
      read_mode_ff <= 1'b0;
      page_ff <= 4'h0;
      load_pending_ff <= 1'b0;
    end
    else if (!ss_active)
    begin
      bit_cnt_ff <= 4'h0;
      in_cmd_ff <= 1'b1;
      load_pending_ff <= 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        shift_in_ff <= word_in;
      end
      if (word_done && in_cmd_ff)
      begin
        in_cmd_ff <= 1'b0;
        read_mode_ff <= word_in[aux_adc_pkg::CMD_RW_BIT];
        page_ff <= word_in[aux_adc_pkg::CMD_PAGE_MSB:
          aux_adc_pkg::CMD_PAGE_LSB];
        load_pending_ff <= word_in[aux_adc_pkg::CMD_RW_BIT];
      end
      else if (word_done && read_mode_ff)
        load_pending_ff <= 1'b1;
      else if (load_fire)
        load_pending_ff <= 1'b0;
    end
  end

  // Register pointer with auto-increment up to page end
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ptr_ff <= 6'h00;
      past_end_ff <= 1'b0;
    end
    else if (ss_active)
    begin
      if (word_done && in_cmd_ff)
      begin
        ptr_ff <= word_in[aux_adc_pkg::CMD_ADDR_MSB:aux_adc_pkg::CMD_ADDR_LSB];
        past_end_ff <= 1'b0;
      end
      else if (load_fire || (word_done && !in_cmd_ff && !read_mode_ff))
      begin
        if (ptr_ff == aux_adc_pkg::ADDR_PAGE_LAST)
          past_end_ff <= 1'b1;
        else
          ptr_ff <= ptr_ff + 6'h01;
      end
    end
  end

  // Result slot behind a data-page address
  always_comb
  begin
    rd_slot_hit = 1'b1;
    rd_slot = aux_adc_pkg::SLOT_BATTERY_ONE_INPUT;
    case (ptr_ff)
      aux_adc_pkg::ADDR_BATTERY_ONE_INPUT: rd_slot = aux_adc_pkg::SLOT_BATTERY_ONE_INPUT;
      aux_adc_pkg::ADDR_BATTERY_TWO_INPUT: rd_slot = aux_adc_pkg::SLOT_BATTERY_TWO_INPUT;
      aux_adc_pkg::ADDR_AUX: rd_slot = aux_adc_pkg::SLOT_AUX;
      aux_adc_pkg::ADDR_TEMPERATURE_ONE: rd_slot = aux_adc_pkg::SLOT_TEMPERATURE_ONE;
      aux_adc_pkg::ADDR_TEMPERATURE_TWO: rd_slot = aux_adc_pkg::SLOT_TEMPERATURE_TWO;
      default: rd_slot_hit = 1'b0;
    endcase
  end

  // Read data: status on read, not the written command
  always_comb
  begin
    read_word = 16'h0000;
    if (past_end_ff)
      read_word = aux_adc_pkg::READ_PAST_END;
    else if (page_ff == aux_adc_pkg::PAGE_DATA)
    begin
      if (rd_slot_hit)
        read_word = {4'h0, result_ff[rd_slot]};
    end
    else if (page_ff == aux_adc_pkg::PAGE_CTRL)
    begin
      if (ptr_ff == aux_adc_pkg::ADDR_CONTROL)
      begin
        read_word[aux_adc_pkg::CTL_BUSY_BIT] = !eng_busy;
        read_word[aux_adc_pkg::CTL_SCAN_MSB:
          aux_adc_pkg::CTL_SCAN_LSB] = scan_ff;
        read_word[aux_adc_pkg::CTL_RES_MSB:aux_adc_pkg::CTL_RES_LSB] = res_ff;
      end
      else if (ptr_ff == aux_adc_pkg::ADDR_STATUS)
      begin
        read_word[aux_adc_pkg::STS_PWRDN_BIT] = stop_ff;
        read_word[aux_adc_pkg::STS_READY_BIT] = ready_ff;
      end
    end
  end

  // Serial output: load on the falling edge after a word, then shift
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_out_ff <= 16'h0000;
      miso_oe_ff <= 1'b0;
    end
    else
    begin
      miso_oe_ff <= ss_active;
      if (!ss_active)
        shift_out_ff <= 16'h0000;
      else if (load_fire)
        shift_out_ff <= read_word;
      else if (sclk_fall)
        shift_out_ff <= {shift_out_ff[14:0], 1'b0};
    end
  end

  // Converter control register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stop_ff <= 1'b0;
      scan_ff <= aux_adc_pkg::SCAN_RESET;
      res_ff <= aux_adc_pkg::RES_RESET;
      start_pulse_ff <= 1'b0;
    end
    else
    begin
      start_pulse_ff <= 1'b0;
      if (ctl_write)
      begin
        // Bit 15 is never stored, so it reads back zero
        stop_ff <= word_in[aux_adc_pkg::CTL_BUSY_BIT];
        scan_ff <= word_in[aux_adc_pkg::CTL_SCAN_MSB:
          aux_adc_pkg::CTL_SCAN_LSB];
        res_ff <= word_in[aux_adc_pkg::CTL_RES_MSB:
          aux_adc_pkg::CTL_RES_LSB];
        start_pulse_ff <= !word_in[aux_adc_pkg::CTL_BUSY_BIT];
      end
    end
  end

  // Result registers: written only by the converter
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < aux_adc_pkg::NUM_SLOTS; i++)
        result_ff[i] <= aux_adc_pkg::RESULT_RESET;
    end
    else if (store_valid)
      result_ff[store_slot] <= store_data;
  end

  // Unread tracking; a new result beats a read in the same cycle
  always_comb
  begin
    nxt_unread = unread_ff;
    if (load_fire && !past_end_ff && (page_ff == aux_adc_pkg::PAGE_DATA)
        && rd_slot_hit)
      nxt_unread[rd_slot] = 1'b0;
    if (store_valid)
      nxt_unread[store_slot] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      unread_ff <= '0;
      ready_ff <= 1'b0;
    end
    else
    begin
      unread_ff <= nxt_unread;
      if (seq_done)
        ready_ff <= 1'b1;
      else if (nxt_unread == '0)
        ready_ff <= 1'b0;
    end
  end

  assign spi_miso = shift_out_ff[15];
  assign spi_miso_oe = miso_oe_ff;
  assign adc_power_down = stop_ff;
  assign results_ready_flag = ready_ff;
endmodule : aux_adc_control_results

// file: aux_adc_control_results_properties.sv
// Port assertions for the converter control and result block
`timescale 1ns/1ps
module aux_adc_control_results_properties (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic spi_sclk,
  input wire logic spi_ss_b,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  input wire logic adc_start,
  input wire logic [2:0] adc_sel,
  input wire logic [1:0] adc_res,
  input wire logic adc_power_down,
  input wire logic results_ready_flag
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_reset_quiet: assert property (
    $rose(rst_b) |-> !adc_start && !adc_power_down && !results_ready_flag)
    else $error("outputs not quiet after reset");
  a_start_pulse: assert property (
    adc_start |=> !adc_start)
    else $error("start pulse longer than one cycle");
  a_stop_holds: assert property (
    adc_power_down |-> !adc_start)
    else $error("conversion started while powered down");
  a_done_gap: assert property (
    adc_done |=> !adc_start)
    else $error("next conversion started right after done");
  a_ready_cause: assert property (
    $rose(results_ready_flag) |->
      $past(adc_done) || $past(adc_done, 2) || $past(adc_done, 3))
    else $error("ready flag set without a finished conversion");
  a_sel_range: assert property (
    adc_start |-> adc_sel <= 3'h4)
    else $error("conversion started on an unknown input");
  a_oe_off: assert property (
    spi_ss_b [*5] |-> !spi_miso_oe)
    else $error("data pin driven while not selected");
  a_oe_on: assert property (
    !spi_ss_b [*5] |-> spi_miso_oe)
    else $error("data pin not driven while selected");
  a_miso_idle: assert property (
    !spi_miso_oe |-> !spi_miso)
    else $error("data pin high while not driven");
  a_res_steady: assert property (
    adc_start |-> $stable(adc_res))
    else $error("resolution changed at conversion start");
endmodule : aux_adc_control_results_properties

bind aux_adc_control_results aux_adc_control_results_properties u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .spi_sclk(spi_sclk),
  .spi_ss_b(spi_ss_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .adc_done(adc_done), .adc_data(adc_data),
  .adc_start(adc_start), .adc_sel(adc_sel), .adc_res(adc_res),
  .adc_power_down(adc_power_down), .results_ready_flag(results_ready_flag)
);

// file: spi_host_model.sv
// Serial host model driving the register port in mode 0
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk,
  output logic ss_b,
  output logic mosi,
  input wire logic miso
);
  localparam int HALF = 160;
  logic [15:0] rd [8];

  initial
  begin
    sclk = 1'b0;
    ss_b = 1'b1;
    mosi = 1'b0;
  end

  // Command word, then n data words, MSB first
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd,
                      input int n);
    logic [15:0] sh;
    // Keep pin edges clear of the system clock edges
    #1;
    ss_b = 1'b0;
    for (int w = 0; w <= n; w++)
    begin
      sh = (w == 0) ? cmd : wd;
      for (int b = 15; b >= 0; b--)
      begin
        mosi = sh[b];
        #HALF sclk = 1'b1;
        #(HALF - 10);
        if (w > 0)
          rd[w-1][b] = miso;
        #10 sclk = 1'b0;
      end
    end
    #HALF ss_b = 1'b1;
    // Released line shows no stale bit
    mosi = ~mosi;
    #(2 * HALF - 1);
  endtask : xfer
endmodule : spi_host_model

// file: aux_adc_control_results_tb.sv
// Self-checking bench for the converter control and result block
`timescale 1ns/1ps
module aux_adc_control_results_tb;
  typedef struct packed {
    logic [3:0] scan;
    logic [1:0] res;
    logic [5:0] addr;
    logic [2:0] sel;
  } row_t;
  logic sys_clk, rst_b, spi_sclk, spi_ss_b, spi_mosi, spi_miso, spi_miso_oe;
  logic adc_done, adc_start, adc_power_down, results_ready_flag, pend;
  logic [11:0] adc_data, salt;
  logic [2:0] adc_sel, sel_seen;
  logic [1:0] adc_res, res_seen;
  logic [9:0] wait_cnt;
  logic [11:0] conv_val [5] = '{12'h9C3, 12'hA5F, 12'h3E1, 12'h7B6, 12'hC2D};
  logic [3:0] rsv [6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'hD, 4'hF};
  row_t rows [6] = '{'{4'h6, 2'h0, 6'h05, 3'h0}, '{4'h7, 2'h1, 6'h06, 3'h1},
    '{4'h8, 2'h2, 6'h07, 3'h2}, '{4'h9, 2'h3, 6'h07, 3'h2},
    '{4'hA, 2'h0, 6'h09, 3'h3}, '{4'hC, 2'h1, 6'h0A, 3'h4}};
  int fails, total_checks, starts, conv_lat, s0;

  aux_adc_control_results u_aux_adc_control_results (
    .sys_clk(sys_clk), .rst_b(rst_b), .spi_sclk(spi_sclk),
    .spi_ss_b(spi_ss_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .adc_done(adc_done), .adc_data(adc_data),
    .adc_start(adc_start), .adc_sel(adc_sel), .adc_res(adc_res),
    .adc_power_down(adc_power_down), .results_ready_flag(results_ready_flag)
  );
  spi_host_model u_spi_host_model (
    .sclk(spi_sclk), .ss_b(spi_ss_b), .mosi(spi_mosi), .miso(spi_miso)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Converter stand-in: answers each start conv_lat + 1 cycles later
  always @(posedge sys_clk)
  begin
    #1;
    adc_done = 1'b0;
    if (adc_start)
    begin
      pend = 1'b1;
      wait_cnt = 10'(conv_lat);
      starts++;
      sel_seen = adc_sel;
      res_seen = adc_res;
    end
    else if (pend && wait_cnt == 10'h000)
    begin
      pend = 1'b0;
      adc_done = 1'b1;
      adc_data = conv_val[adc_sel] ^ salt;
    end
    else if (pend)
      wait_cnt = wait_cnt - 10'h001;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd1(input logic [15:0] cmd, output logic [15:0] v);
    u_spi_host_model.xfer(cmd, 16'h0000, 1);
    v = u_spi_host_model.rd[0];
  endtask : rd1

  task automatic wr_ctl(input logic [15:0] v);
    u_spi_host_model.xfer(16'h0800, v, 1);
  endtask : wr_ctl

  task automatic wait_ready();
    for (int i = 0; i < 3000 && results_ready_flag !== 1'b1; i++)
      @(posedge sys_clk);
    check(16'(results_ready_flag), 16'h0001);
  endtask : wait_ready

  function automatic logic [15:0] exp_word(input logic [1:0] res,
                                           input logic [11:0] v);
    case (res)
      2'h1: return {8'h00, v[7:0]};
      2'h2: return {6'h00, v[9:0]};
      default: return {4'h0, v};
    endcase
  endfunction : exp_word

  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  initial
  begin
    #2400000;
    fails++;
    test_done();
  end

  initial
  begin
    logic [15:0] v;
    rst_b = 1'b0;
    adc_done = 1'b0;
    adc_data = 12'h000;
    pend = 1'b0;
    salt = 12'h000;
    conv_lat = 30;
    repeat (10) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    u_spi_host_model.xfer(16'h80A0, 16'h0000, 6);
    for (int i = 0; i < 6; i++)
      if (i != 3)
        check(u_spi_host_model.rd[i], 16'h0000);
    rd1(16'h8800, v);
    check(v, 16'h4000);
    check(16'(spi_miso_oe), 16'h0000);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr_ctl({2'b00, rows[i].scan, rows[i].res, 8'h00});
      wait_ready();
      check(16'(sel_seen), 16'(rows[i].sel));
      check(16'(res_seen), 16'(rows[i].res));
      rd1({5'h10, rows[i].addr, 5'h00}, v);
      check(v, exp_word(rows[i].res, conv_val[rows[i].sel]));
      check(16'(results_ready_flag), 16'h0000);
      rd1(16'h8800, v);
      check(v, {2'b01, rows[i].scan, rows[i].res, 8'h00});
    end
    $display("test single conversions done");
    s0 = starts;
    foreach (rsv[i])
    begin
      wr_ctl({2'b00, rsv[i], 10'h000});
      repeat (100) @(posedge sys_clk);
    end
    check(16'(starts), 16'(s0));
    $display("test reserved codes done");
    salt = 12'h111;
    wr_ctl(16'h2C00);
    wait_ready();
    u_spi_host_model.xfer(16'h80A0, 16'h0000, 3);
    for (int i = 0; i < 3; i++)
      check(u_spi_host_model.rd[i], {4'h0, conv_val[i] ^ salt});
    check(16'(results_ready_flag), 16'h0000);
    u_spi_host_model.xfer(16'h00A0, 16'h1234, 1);
    rd1(16'h80A0, v);
    check(v, {4'h0, conv_val[0] ^ salt});
    wr_ctl(16'h8000);
    rd1(16'h8800, v);
    check(v, 16'h4000);
    u_spi_host_model.xfer(16'h8BE0, 16'h0000, 2);
    check(u_spi_host_model.rd[1], 16'hFFFF);
    $display("test scan and access done");
    conv_lat = 1000;
    salt = 12'h0F0;
    wr_ctl(16'h1800);
    rd1(16'h8800, v);
    check(v, 16'h1800);
    wr_ctl(16'h5800);
    check(16'(adc_power_down), 16'h0001);
    repeat (1100) @(posedge sys_clk);
    rd1(16'h80A0, v);
    check(v, {4'h0, conv_val[0] ^ 12'h111});
    rd1(16'h8820, v);
    check(v, 16'h2000);
    wr_ctl(16'h0000);
    check(16'(adc_power_down), 16'h0000);
    $display("test abort done");
    @(posedge sys_clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    rd1(16'h80A0, v);
    check(v, 16'h0000);
    rd1(16'h8800, v);
    check(v, 16'h4000);
    check(16'(results_ready_flag), 16'h0000);
    $display("test mid-run reset done");
    test_done();
  end
endmodule : aux_adc_control_results_tb
